// >>> pvc_cfg.svh
// Purpose: Constants of the voice port (offsets, fields, resets, counts)
// Assumes: Included by bare name wherever a constant is needed
// Notes: Byte addresses on a 32-bit classic Wishbone slave
`ifndef PVC_CFG_SVH
`define PVC_CFG_SVH
// Register byte addresses
`define PVC_A_CFG 8'h00
`define PVC_A_SYN 8'h04
`define PVC_A_TX 8'h08
`define PVC_A_RX 8'h0C
`define PVC_A_STA 8'h10
// Reset values
`define PVC_CFG_RST 32'h0080_0000
`define PVC_SYN_RST 32'h0808_0177
// Configuration word bits
`define PVC_B_FOLLOW 1
`define PVC_B_SHORT 2
`define PVC_B_SIGNX 4
`define PVC_B_LSBF 5
`define PVC_B_REL 6
`define PVC_B_RELRISE 7
`define PVC_B_HOLD 8
`define PVC_B_ISDN 9
`define PVC_B_MUTE 10
`define PVC_B_FAST 11
`define PVC_B_LONG16 12
`define PVC_F_RATE 22:21
`define PVC_F_SLOT 26:23
`define PVC_F_FMT 28:27
// Fractional synthesiser word fields
`define PVC_F_MOD 12:0
`define PVC_F_INC 23:16
`define PVC_F_DIV 31:24
// Sample format and rate codes
`define PVC_FMT13 2'h0
`define PVC_FMT16 2'h1
`define PVC_FMT8 2'h2
`define PVC_FMT8S 2'h3
`define PVC_R128 2'h1
`define PVC_R512 2'h2
// Fixed-rate synthesiser: increment over modulus 625 at 10 MHz
`define PVC_FIX_MOD 13'h0271
`define PVC_FIX_I128 13'h0010
`define PVC_FIX_I256 13'h0020
`define PVC_FIX_I512 13'h0040
// Strobe lengths, slot count, gain field of the transmit word
`define PVC_SYNC8 11'h008
`define PVC_SYNC16 11'h010
`define PVC_SLOTS 8'h04
`define PVC_F_GAIN 18:16
`endif

// >>> pvc_pkg.sv
// Purpose: Types shared by the voice port
// Assumes: Constants come from pvc_cfg.svh
// Notes: Bus request travels as one packed struct
package pvc_pkg;
  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pvc_wb_req_t;
  // Position of one bit within the frame
  typedef struct packed {
    logic       act;
    logic       last;
    logic       nact;
    logic [3:0] pos;
  } pvc_slot_t;
  // Whole state of the voice port
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] syn;
    logic [31:0] tx;
    logic [15:0] rx;
    logic        rx_rdy;
    logic [15:0] rx_sh;
    logic [12:0] acc;
    logic [10:0] cnt;
    logic [10:0] learn;
    logic        bclk_o;
    logic        bclk_oe_n;
    logic        strobe_o;
    logic        strobe_oe_n;
    logic        dout_o;
    logic        dout_oe_n;
    logic        bs1, bs2, bs3;
    logic        ss1, ss2, st_prev;
    logic        ds1, ds2;
    logic        ack;
    logic [31:0] rdat;
  } pvc_state_t;
endpackage

// >>> pvc_voice_port.sv
// Purpose: PCM voice port clocking, framing and serial data
// Assumes: 10 MHz system clock; pins are synchronised inside
// Notes: Registers on classic Wishbone, one-cycle registered answer
`timescale 1ns/1ns
`include "pvc_cfg.svh"

// Summary of operation
// - Bit 9 sets the ISDN circuit mode flag, read in status bit 2; bit clock up to 4096 kHz.
// - Fixed-rate leader gives 128, 256 or 512 kHz, strobe at 8 kHz.
// - Bit 11 selects the fractional synthesiser, clear selects fixed-rate.
// - Bit 12 sets long strobe 16 cycles, else 8; fractional long only.
// - Fractional bit clock equals increment over modulus times base rate.
// - Fractional strobe rate equals bit clock over divisor times 8.
// - Synth word: modulus 12:0, increment 23:16, divisor 31:24.
// - Configuration word resets to 0x00800000.
// - Bit 1 clear: leader drives clock and strobe; set: follower.
// - Bit 2 clear: rising strobe starts frame; set: falling starts.
// - Sign fill set extends sign; clear pads gain bits or zeros.
// - Bit order clear sends MSB first, set sends LSB first.
// - Release clear drives output always; set releases after active slot.
// - Release edge clear: after falling edge; set: after rising edge.
// - Bit 8 holds leader strobe inactive while clock keeps running.
// - Bit 10 forces serial output to zero.
// - Rate field 22:21: 01 128 kHz, 00 256 kHz, 10 512 kHz.
// - Slot field 26:23 resets to 0001.
// - Format 28:27: 13, 16, 8 bit in 16 cycles; 11 is 8 in 8.
// - Input sampled on falling edge, output changed on rising edge.
// - Short framing strobe is one bit clock cycle long.
// - Any subset of the first four slots may carry data.
// - Eight-cycle slots are used only with 8-bit samples.
module pvc_voice_port
  import pvc_pkg::*;
(
  // System
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Wishbone slave
  input  wire pvc_wb_req_t wb_req_in,
  output logic             wb_ack_out,
  output logic [31:0]      wb_dat_out,
  // Bit clock pin
  input  wire logic        bclk_in,
  output logic             bclk_out,
  output logic             bclk_oe_n_out,
  // Frame strobe pin
  input  wire logic        strobe_in,
  output logic             strobe_out,
  output logic             strobe_oe_n_out,
  // Serial data pins
  input  wire logic        din_in,
  output logic             dout_out,
  output logic             dout_oe_n_out
);

  pvc_state_t s;
  pvc_state_t n;
  logic       rise_w;
  logic       fall_w;
  logic       lead_w;
  logic [10:0] frame_w;

  // Slot, bit position and neighbour activity of one frame count
  function automatic pvc_slot_t slot_of(input logic [10:0] c, input logic l8,
                                        input logic [3:0] m);
    pvc_slot_t r;
    logic [7:0] sl;
    sl     = l8 ? c[10:3] : {1'b0, c[10:4]};
    r.pos  = l8 ? {1'b0, c[2:0]} : c[3:0];
    r.act  = (sl < `PVC_SLOTS) && m[sl[1:0]];
    r.last = l8 ? (c[2:0] == 3'h7) : (c[3:0] == 4'hF);
    r.nact = (sl < `PVC_SLOTS - 8'h01) && m[sl[1:0] + 2'h1];
    return r;
  endfunction

  // Bit of the slot word sent or received at a slot position
  function automatic logic [3:0] idx_of(input logic [3:0] p, input logic l8,
                                        input logic lsbf);
    if (!lsbf) begin
      return 4'hF - p;
    end else if (l8) begin
      return 4'h8 + p;
    end
    return p;
  endfunction

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    logic        l8;
    logic        fast;
    logic [12:0] mod;
    logic [12:0] inc;
    logic [13:0] sum;
    logic        wrap;
    logic [10:0] nc;
    logic [10:0] slen;
    logic [15:0] word;
    logic [1:0]  fmt;
    logic        strt;
    logic [10:0] rc;
    pvc_slot_t   si;
    logic        rd_rx;
    n      = s;
    rise_w = 1'b0;
    fall_w = 1'b0;
    nc     = s.cnt;
    rc     = s.cnt;
    strt   = 1'b0;
    rd_rx  = 1'b0;
    si     = '0;
    fmt    = s.cfg[`PVC_F_FMT];
    l8     = (fmt == `PVC_FMT8S);
    fast   = s.cfg[`PVC_B_FAST];
    lead_w = !s.cfg[`PVC_B_FOLLOW];

    // Pin synchronisers, two flops each, three on the bit clock
    n.bs1 = bclk_in;
    n.bs2 = s.bs1;
    n.bs3 = s.bs2;
    n.ss1 = strobe_in;
    n.ss2 = s.ss1;
    n.ds1 = din_in;
    n.ds2 = s.ds1;

    // Synthesiser select and increment
    if (fast) begin
      mod = s.syn[`PVC_F_MOD];
      inc = {5'h00, s.syn[`PVC_F_INC]};
    end else begin
      mod = `PVC_FIX_MOD;
      case (s.cfg[`PVC_F_RATE])
        `PVC_R128: inc = `PVC_FIX_I128;
        `PVC_R512: inc = `PVC_FIX_I512;
        default:   inc = `PVC_FIX_I256;
      endcase
    end

    // Accumulator; as leader, each wrap toggles the bit clock
    sum  = {1'b0, s.acc} + {1'b0, inc};
    wrap = (mod != 13'h0000) && (sum >= {1'b0, mod});
    if (mod == 13'h0000) begin
      n.acc = 13'h0000;
    end else if (wrap) begin
      n.acc = 13'(sum - {1'b0, mod});
    end else begin
      n.acc = sum[12:0];
    end

    // Frame length in bit clocks
    if (!lead_w) begin
      frame_w = s.learn;
    end else if (!fast) begin
      frame_w = 11'(inc);                           // 8 kHz frames
    end else if (s.syn[`PVC_F_DIV] == 8'h00) begin
      frame_w = `PVC_SYNC8;
    end else begin
      frame_w = {s.syn[`PVC_F_DIV], 3'h0};
    end

    // Bit clock edges, generated or seen on the pin
    if (lead_w) begin
      if (wrap) begin
        n.bclk_o = !s.bclk_o;
      end
      rise_w = wrap && !s.bclk_o;
      fall_w = wrap && s.bclk_o;
    end else begin
      rise_w = s.bs2 && !s.bs3;
      fall_w = !s.bs2 && s.bs3;
    end
    n.bclk_oe_n   = !lead_w;
    n.strobe_oe_n = !lead_w;

    // Long strobe length
    slen = (fast && s.cfg[`PVC_B_LONG16]) ? `PVC_SYNC16 : `PVC_SYNC8;

    // Slot word from the transmit register
    case (fmt)
      `PVC_FMT13: word = s.cfg[`PVC_B_SIGNX] ?
                         {{3{s.tx[12]}}, s.tx[12:0]} :
                         {s.tx[12:0], s.tx[`PVC_F_GAIN]};
      `PVC_FMT16: word = s.tx[15:0];
      `PVC_FMT8:  word = s.cfg[`PVC_B_SIGNX] ?
                         {{8{s.tx[7]}}, s.tx[7:0]} : {s.tx[7:0], 8'h00};
      default:    word = {s.tx[7:0], 8'h00};
    endcase

    // Rising edge: advance frame, drive output and strobe
    if (rise_w) begin
      // Leader wraps at its own frame length; follower restarts on the
      // strobe edge already seen, so bit 0 of every frame is not lost
      nc = s.cnt + 11'h001;
      if (lead_w && nc >= frame_w) begin
        nc = 11'h000;
      end else if (!lead_w && (s.cfg[`PVC_B_SHORT] ? (!s.ss2 && s.st_prev) :
                                                  (s.ss2 && !s.st_prev))) begin
        nc = 11'h000;
      end
      n.cnt = nc;
      si = slot_of(nc, l8, s.cfg[`PVC_F_SLOT]);
      n.dout_o = si.act && !s.cfg[`PVC_B_MUTE] &&
                 word[idx_of(si.pos, l8, s.cfg[`PVC_B_LSBF])];
      if (si.act) begin
        n.dout_oe_n = 1'b0;
      end else if (s.cfg[`PVC_B_RELRISE]) begin
        n.dout_oe_n = 1'b1;
      end
      if (s.cfg[`PVC_B_SHORT]) begin
        n.strobe_o = (nc == frame_w - 11'h001);
      end else begin
        n.strobe_o = (nc < slen);
      end
    end

    // Falling edge: frame detect as follower, sample input
    if (fall_w) begin
      n.st_prev = s.ss2;
      if (!lead_w) begin
        strt = s.cfg[`PVC_B_SHORT] ? (!s.ss2 && s.st_prev) :
                                     (s.ss2 && !s.st_prev);
      end
      if (strt) begin
        rc = 11'h000;
        n.cnt = 11'h000;
        if (s.cnt != 11'h000) begin
          n.learn = s.cnt + 11'h001;
        end
      end
      si = slot_of(rc, l8, s.cfg[`PVC_F_SLOT]);
      if (si.act) begin
        n.rx_sh[idx_of(si.pos, l8, s.cfg[`PVC_B_LSBF])] = s.ds2;
      end
      if (si.act && si.last) begin
        n.rx = n.rx_sh;
        if (!s.cfg[`PVC_B_RELRISE] && !si.nact) begin
          n.dout_oe_n = 1'b1;
        end
      end
    end

    // Output release off: drive continuously; mute and strobe hold
    if (!s.cfg[`PVC_B_REL]) begin
      n.dout_oe_n = 1'b0;
    end
    if (s.cfg[`PVC_B_MUTE]) begin
      n.dout_o = 1'b0;
    end
    if (!lead_w || s.cfg[`PVC_B_HOLD]) begin
      n.strobe_o = 1'b0;
    end
    if (!lead_w) begin
      n.bclk_o = 1'b0;
    end

    // Wishbone slave: answer one cycle after the request
    n.ack = wb_req_in.cyc && wb_req_in.stb && !s.ack;
    if (n.ack) begin
      if (wb_req_in.adr == `PVC_A_CFG) begin
        n.rdat = s.cfg;
      end else if (wb_req_in.adr == `PVC_A_SYN) begin
        n.rdat = s.syn;
      end else if (wb_req_in.adr == `PVC_A_TX) begin
        n.rdat = s.tx;
      end else if (wb_req_in.adr == `PVC_A_RX) begin
        n.rdat = {16'h0000, s.rx};
        rd_rx  = !wb_req_in.we;
      end else if (wb_req_in.adr == `PVC_A_STA) begin
        n.rdat = {5'h00, s.cnt, 13'h0000, s.cfg[`PVC_B_ISDN],
                  lead_w, s.rx_rdy};
      end else begin
        n.rdat = 32'h0000_0000;
      end
      for (int b = 0; b < 4; b++) begin
        if (wb_req_in.we && wb_req_in.sel[b]) begin
          if (wb_req_in.adr == `PVC_A_CFG) begin
            n.cfg[8*b +: 8] = wb_req_in.dat[8*b +: 8];
          end else if (wb_req_in.adr == `PVC_A_SYN) begin
            n.syn[8*b +: 8] = wb_req_in.dat[8*b +: 8];
          end else if (wb_req_in.adr == `PVC_A_TX) begin
            n.tx[8*b +: 8] = wb_req_in.dat[8*b +: 8];
          end
        end
      end
    end

    // Receive ready: a new word wins over a read clear
    if (rd_rx) begin
      n.rx_rdy = 1'b0;
    end
    if (fall_w && si.act && si.last) begin
      n.rx_rdy = 1'b1;
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s             <= '0;
      s.cfg         <= `PVC_CFG_RST;
      s.syn         <= `PVC_SYN_RST;
      s.bclk_oe_n   <= 1'b1;
      s.strobe_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_out      = s.ack;
  assign wb_dat_out      = s.rdat;
  assign bclk_out        = s.bclk_o;
  assign bclk_oe_n_out   = s.bclk_oe_n;
  assign strobe_out      = s.strobe_o;
  assign strobe_oe_n_out = s.strobe_oe_n;
  assign dout_out        = s.dout_o;
  assign dout_oe_n_out   = s.dout_oe_n;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  logic [10:0] hi_cnt;
  logic        long_ok;
  logic [10:0] slen_w;

  // Expected long strobe length for the current settings
  assign slen_w = (s.cfg[`PVC_B_FAST] && s.cfg[`PVC_B_LONG16]) ?
                  `PVC_SYNC16 : `PVC_SYNC8;

  // Bit clocks counted while the strobe is high
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hi_cnt <= 11'h000;
    end else if (rise_w) begin
      hi_cnt <= n.strobe_o ? hi_cnt + 11'h001 : 11'h000;
    end
  end

  // Strobe began cleanly at frame start with no setting changed since
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      long_ok <= 1'b0;
    end else if (n.cfg != s.cfg || n.syn != s.syn) begin
      long_ok <= 1'b0;
    end else if (!s.strobe_o && n.strobe_o && n.cnt == 11'h000) begin
      long_ok <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence seq_rise;
    rise_w;
  endsequence
  sequence seq_lead_long;
    lead_w && !s.cfg[`PVC_B_SHORT] && !s.cfg[`PVC_B_HOLD];
  endsequence

  AST_MUTE: assert property (seq_rise and s.cfg[`PVC_B_MUTE] |=> !s.dout_o)
    else $error("muted output not zero");
  AST_HOLD: assert property (s.cfg[`PVC_B_HOLD] |=> !s.strobe_o)
    else $error("held strobe went high");
  AST_FOLLOW: assert property (s.cfg[`PVC_B_FOLLOW] |=> s.bclk_oe_n && s.strobe_oe_n)
    else $error("follower drives clock or strobe");
  AST_SHORT: assert property (seq_rise and lead_w and s.cfg[`PVC_B_SHORT]
    and s.strobe_o |=> !s.strobe_o)
    else $error("short strobe longer than one bit");
  AST_LONG: assert property (seq_lead_long ##0 $fell(s.strobe_o) ##0 long_ok |->
    $past(hi_cnt) == $past(slen_w))
    else $error("long strobe length wrong");
  AST_FIX_FRAME: assert property (seq_rise and lead_w and !s.cfg[`PVC_B_FAST]
    |=> s.cnt < $past(frame_w))
    else $error("fixed-rate frame too long");
  AST_DIV: assert property (seq_rise and lead_w and s.cfg[`PVC_B_FAST]
    |=> s.cnt < $past({s.syn[`PVC_F_DIV], 3'h0}) || $past(s.syn[`PVC_F_DIV]) == 8'h00)
    else $error("fractional frame too long");
  AST_DDS: assert property (s.cfg[`PVC_B_FAST] && $stable(s.syn) &&
    s.acc < s.syn[`PVC_F_MOD] |=> s.acc < s.syn[`PVC_F_MOD])
    else $error("accumulator beyond modulus");
  AST_DRIVE: assert property (!s.cfg[`PVC_B_REL] ##1 !s.cfg[`PVC_B_REL]
    |-> !s.dout_oe_n)
    else $error("output released while release off");
  AST_EDGE: assert property ($changed(s.dout_o) && !$past(s.cfg[`PVC_B_MUTE])
    |-> $past(rise_w))
    else $error("output changed off rising edge");

endmodule // pvc_voice_port

// >>> pvc_codec_model.sv
// Purpose: Far-side codec model of the voice port
// Assumes: Pins are watched on the 10 MHz system clock
// Notes: Clock always runs; strobe is generated only while follow_in is high
`timescale 1ns/1ns
module pvc_codec_model (
  // System
  input  wire logic        clk_sys_in,
  // Bench control
  input  wire logic        follow_in,
  input  wire logic [4:0]  nbits_in,
  input  wire logic [15:0] rx_word_in,
  // Device pins
  input  wire logic        bclk_dev_in,
  input  wire logic        bclk_oe_n_in,
  input  wire logic        strobe_dev_in,
  input  wire logic        strobe_oe_n_in,
  input  wire logic        dout_in,
  input  wire logic        dout_oe_n_in,
  // Line levels and captures
  output logic             bclk_line_out,
  output logic             strobe_line_out,
  output logic             din_out,
  output logic [15:0]      cap_word_out,
  output logic             oe_rise_out
);
  logic [4:0]  gen_cnt_reg  = 5'h00;
  logic [4:0]  gen_bit_reg  = 5'h00;
  logic        gen_bclk_reg = 1'b0;
  logic        gen_st_reg   = 1'b0;
  logic        pb_reg       = 1'b0;
  logic        ps_reg       = 1'b0;
  logic        din_reg      = 1'b0;
  logic        oe_reg       = 1'b0;
  logic [5:0]  bit_reg      = 6'h00;
  logic [15:0] sh_reg       = 16'h0000;
  logic [15:0] cap_reg      = 16'h0000;
  logic        dout_w;
  logic [5:0]  nb_w;
  // ********
  // Line levels
  // ********
  assign bclk_line_out   = bclk_oe_n_in ? gen_bclk_reg : bclk_dev_in;
  assign strobe_line_out = strobe_oe_n_in ? gen_st_reg : strobe_dev_in;
  assign dout_w          = dout_oe_n_in ? ~dout_in : dout_in; // Released line, no stale level
  assign nb_w            = (strobe_line_out && !ps_reg) ? 6'h00 : bit_reg + 6'h01;
  assign din_out         = din_reg;
  assign cap_word_out    = cap_reg;
  assign oe_rise_out     = oe_reg;
  // Leading clock at 250 kHz, 32-bit frame, 8-bit long strobe
  always @(posedge clk_sys_in) begin
    gen_cnt_reg <= (gen_cnt_reg == 5'h13) ? 5'h00 : gen_cnt_reg + 5'h01;
    if (gen_cnt_reg == 5'h13) begin
      gen_bclk_reg <= ~gen_bclk_reg;
      if (!gen_bclk_reg) begin
        gen_bit_reg <= gen_bit_reg + 5'h01;
        gen_st_reg  <= follow_in && (gen_bit_reg + 5'h01 < 5'h08);
      end
    end
  end
  // Frame tracking: drive input on rise, capture output on fall
  always @(posedge clk_sys_in) begin
    pb_reg <= bclk_line_out;
    if (bclk_line_out && !pb_reg) begin
      ps_reg  <= strobe_line_out;
      bit_reg <= nb_w;
      din_reg <= (nb_w < 6'h10) ? rx_word_in[4'hf - nb_w[3:0]] : ~din_reg;
    end
    if (!bclk_line_out && pb_reg && bit_reg < {1'b0, nbits_in}) begin
      sh_reg <= {sh_reg[14:0], dout_w};
      if (bit_reg == {1'b0, nbits_in} - 6'h01) cap_reg <= {sh_reg[14:0], dout_w};
      if (bit_reg == {1'b0, nbits_in} - 6'h01) oe_reg <= dout_oe_n_in;
    end
  end
endmodule // pvc_codec_model

// >>> pvc_voice_port_bench.sv
// Purpose: Self-checking bench of the voice port
// Assumes: 10 MHz clock, codec model on the pins
// Notes: Random data from a fixed seed
`timescale 1ns/1ns
`include "pvc_cfg.svh"
module pvc_voice_port_bench
  import pvc_pkg::*;
;
  logic        clk_sys_in = 1'b0;
  logic        rst_in     = 1'b1;
  pvc_wb_req_t wb_req     = '0;
  logic        follow     = 1'b0;
  logic [4:0]  nbits      = 5'h10;
  logic [15:0] rx_word    = 16'h0000;
  logic        wb_ack, bclk_o, bclk_oe_n, st_o, st_oe_n, dout_o, dout_oe_n;
  logic        bclk_w, st_w, din_w, oe_rise, sx, lf, pb, ps;
  logic [15:0] cap, m;
  logic [31:0] wb_dat, rd, cfg, tx, syn;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          cyc, rises, hi, inc, div, sr, br;
  int          incs[4] = '{5, 10, 25, 50};
  // Clock
  always #50 clk_sys_in = ~clk_sys_in;
  // Design and far side
  pvc_voice_port i_pvc_voice_port (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .wb_req_in(wb_req), .wb_ack_out(wb_ack), .wb_dat_out(wb_dat),
    .bclk_in(bclk_w), .bclk_out(bclk_o), .bclk_oe_n_out(bclk_oe_n),
    .strobe_in(st_w), .strobe_out(st_o), .strobe_oe_n_out(st_oe_n),
    .din_in(din_w), .dout_out(dout_o), .dout_oe_n_out(dout_oe_n));
  pvc_codec_model i_pvc_codec_model (.clk_sys_in(clk_sys_in), .follow_in(follow),
    .nbits_in(nbits), .rx_word_in(rx_word), .bclk_dev_in(bclk_o), .bclk_oe_n_in(bclk_oe_n),
    .strobe_dev_in(st_o), .strobe_oe_n_in(st_oe_n), .dout_in(dout_o),
    .dout_oe_n_in(dout_oe_n), .bclk_line_out(bclk_w), .strobe_line_out(st_w),
    .din_out(din_w), .cap_word_out(cap), .oe_rise_out(oe_rise));
  // ********
  // Tasks
  // ********
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk_sys_in);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    // Settled ack and data, as the next rising edge samples them
    do begin
      @(negedge clk_sys_in);
      t++;
    end while (wb_ack !== 1'b1 && t < 20);
    q = wb_dat;
    if (t >= 20) check("bus ack", 1, 0);
    @(posedge clk_sys_in);
    wb_req <= '0;
    @(posedge clk_sys_in);
  endtask
  task automatic frames(input int n);
    int k;
    k = 0;
    ps = st_w;
    while (k < n) begin
      @(negedge clk_sys_in);
      if (st_w && !ps) k++;
      ps = st_w;
    end
  endtask
  // Skip a partial and a whole frame, then measure the next whole frame
  task automatic measure;
    int n;
    n = 0;
    cyc = 0;
    rises = 0;
    hi = 0;
    pb = bclk_w;
    ps = st_w;
    while (n < 3) begin
      @(negedge clk_sys_in);
      if (st_w && !ps) n++;
      if (n == 2) cyc++;
      if (n == 2 && bclk_w && !pb) rises++;
      if (n == 2 && bclk_w && !pb && st_w) hi++;
      pb = bclk_w;
      ps = st_w;
    end
  endtask
  function automatic logic [15:0] exp_slot(input logic [1:0] f, input logic s,
                                           input logic l, input logic [31:0] t);
    logic [15:0] w;
    logic [15:0] r;
    int n;
    case (f)
      `PVC_FMT13: w = s ? {{3{t[12]}}, t[12:0]} : {t[12:0], t[`PVC_F_GAIN]};
      `PVC_FMT16: w = t[15:0];
      `PVC_FMT8: w = s ? {{8{t[7]}}, t[7:0]} : {t[7:0], 8'h00};
      default: w = {8'h00, t[7:0]};
    endcase
    n = (f == `PVC_FMT8S) ? 8 : 16;
    r = w;
    for (int k = 0; k < n; k++) if (l) r[k] = w[n - 1 - k];
    return r;
  endfunction
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (98000) @(posedge clk_sys_in);
    num_errors++;
    results();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    void'($urandom(32'h1f1f_85ab));
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    wb(0, `PVC_A_CFG, 0, rd);
    check("cfg reset", `PVC_CFG_RST, rd);
    check("slot field", 32'h0000_0001, {28'h0, rd[`PVC_F_SLOT]});
    wb(0, `PVC_A_SYN, 0, rd);
    check("synth reset", `PVC_SYN_RST, rd);
    wb(0, 8'h20, 0, rd);
    check("unmapped read", 0, rd);
    // Fixed rates, one with the 16-bit strobe bit ignored
    for (int r = 0; r < 4; r++) begin
      cfg = `PVC_CFG_RST;
      cfg[`PVC_F_RATE] = r[1:0];
      cfg[`PVC_B_LONG16] = (r == 3);
      wb(1, `PVC_A_CFG, cfg, rd);
      measure();
      check("frame cycles", 1250, cyc);
      check("clock rises", (r == 1) ? 16 : (r == 2) ? 64 : 32, rises);
      check("strobe length", 8, hi);
    end
    wb(1, `PVC_A_CFG, 32'h0080_0004, rd);
    measure();
    check("short strobe", 1, hi);
    // Fractional synthesiser, random increment and divisor
    for (int k = 0; k < 2; k++) begin
      inc = incs[$urandom % 4];
      div = 3 + $urandom % 2;
      syn = {div[7:0], inc[7:0], 16'h00fa};
      wb(1, `PVC_A_SYN, syn, rd);
      wb(0, `PVC_A_SYN, 0, rd);
      check("synth word", syn, rd);
      wb(1, `PVC_A_CFG, 32'h0080_0800 | (k << 12), rd);
      measure();
      check("frac frame", 4000 * div / inc, cyc);
      check("frac bits", 8 * div, rises);
      check("frac strobe", (k == 1) ? 16 : 8, hi);
    end
    // Every sample format with random fill; random bit order except 16-bit
    for (int i = 0; i < 4; i++) begin
      tx = $urandom;
      sx = 1'($urandom);
      lf = (i == 1) ? 1'b0 : 1'($urandom);
      rx_word <= 16'($urandom);
      nbits <= (i == 3) ? 5'h08 : 5'h10;
      cfg = `PVC_CFG_RST;
      cfg[`PVC_F_FMT] = i[1:0];
      cfg[`PVC_B_LSBF] = lf;
      cfg[`PVC_B_SIGNX] = sx;
      wb(1, `PVC_A_TX, tx, rd);
      wb(1, `PVC_A_CFG, cfg, rd);
      frames(3);
      m = (i == 3) ? 16'h00ff : 16'hffff;
      check("slot word", exp_slot(i[1:0], sx, lf, tx) & m, cap & m);
      wb(0, `PVC_A_RX, 0, rd);
      if (i == 1) check("rx word", {16'h0000, rx_word}, rd);
    end
    // Mute with continuous drive
    nbits <= 5'h10;
    wb(1, `PVC_A_TX, 32'h0000_ffff, rd);
    wb(1, `PVC_A_CFG, 32'h0088_0400, rd);
    frames(3);
    check("muted word", 0, cap);
    repeat (800) @(posedge clk_sys_in);
    check("driven out", 0, dout_oe_n);
    // Release after falling, then after rising edge
    for (int k = 0; k < 2; k++) begin
      wb(1, `PVC_A_CFG, 32'h0088_0040 | (k << 7), rd);
      frames(3);
      check("release edge", (k == 1) ? 0 : 1, oe_rise);
      repeat (800) @(posedge clk_sys_in);
      check("released out", 1, dout_oe_n);
    end
    // Strobe held while clock runs, circuit mode flag
    wb(1, `PVC_A_CFG, 32'h0080_0300, rd);
    wb(0, `PVC_A_STA, 0, rd);
    check("circuit flag", 1, rd[2]);
    sr = 0;
    br = 0;
    pb = bclk_w;
    ps = st_w;
    repeat (2600) begin
      @(negedge clk_sys_in);
      sr += (st_w && !ps);
      br += (bclk_w && !pb);
      pb = bclk_w;
      ps = st_w;
    end
    check("held strobe", 0, sr);
    check("clock runs", 1, br > 60);
    // Follower fed by the codec model
    follow <= 1'b1;
    tx = $urandom;
    wb(1, `PVC_A_TX, tx, rd);
    wb(1, `PVC_A_CFG, 32'h0088_0002, rd);
    check("clock released", 1, bclk_oe_n);
    check("strobe released", 1, st_oe_n);
    frames(4);
    check("follower word", exp_slot(`PVC_FMT13, 1'b0, 1'b0, tx), cap);
    results();
  end
endmodule // pvc_voice_port_bench
